// ---- pmfa_mac_model.sv ----
// MAC-side model driving the 10 Mb/s serial transmit inputs
`default_nettype none
module pmfa_mac_model (
  // MII transmit
  input  wire logic tx_clk,
  input  wire logic send,
  output var  logic tx_en,
  output var  logic txd
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tx_en = 1'b0;
    txd   = 1'b0;
  end
  // Change on the falling edge so data is steady at the rising edge
  always @(negedge tx_clk) begin
    tx_en <= send;
    txd   <= ~txd;
  end
endmodule
`default_nettype wire

// ---- pmfa_media_path.sv ----
// Media path: 10 Mb/s coder, fiber mode, far-end fault, port select
`default_nettype none
module pmfa_media_path
  import pmfa_pkg::*;
#(
  parameter logic [4:0]  PHY_ADDR      = 5'h01,
  parameter int unsigned JABBER_CYCLES = JABBER_CYCLES_DEF,
  parameter int unsigned UNJAB_CYCLES  = UNJAB_CYCLES_DEF
) (
  // Clocks and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic lclk,
  // Serial management
  input  wire logic mdc,
  input  wire logic mdio_in,
  output var  logic mdio_out,
  output var  logic mdio_oe,
  // Straps and link state
  input  wire logic fiber_strap_n,
  input  wire logic link_pulse_ok,
  // 100 Mb/s code stream
  input  wire logic tx_code_bit,
  input  wire logic tx_code_idle,
  output var  logic rx_code_bit,
  output var  logic rx_carrier100,
  output var  logic far_fault_signalling,
  // 100 Mb/s media
  input  wire logic fiber_rx_pair,
  input  wire logic copper_rx_pair,
  input  wire logic fiber_signal_detect,
  output var  logic fiber_tx_pair,
  output var  logic copper_tx_pair,
  // 10 Mb/s MII
  input  wire logic tx_en,
  input  wire logic txd,
  output var  logic tx_clk,
  output var  logic rx_clk,
  output var  logic rxd,
  output var  logic crs,
  // 10 Mb/s media
  input  wire logic tp10_rx_line,
  input  wire logic attach_rx_pair,
  output var  logic tp10_tx_line,
  output var  logic attach_tx_pair,
  output var  logic tx10_drive,
  output var  logic thin_select
);
  localparam logic [25:0] JAB_LAST   = 26'(JABBER_CYCLES - 1);
  localparam logic [25:0] UNJAB_LAST = 26'(UNJAB_CYCLES - 1);

  pmfa_cfg_t        cfg;
  pmfa_mgmt_state_t mg_state;
  pmfa_mgmt_hdr_t   hdr;
  logic [8:0]       sync_m1;
  logic [8:0]       sync_m2;
  logic             mdc_s3;
  logic [5:0]       ones_cnt;
  logic [3:0]       bit_cnt;
  logic [15:0]      shreg;
  logic [1:0]       cap_cnt;
  logic             strap_fiber;
  logic             rf_latch;
  logic             far_fault_det;
  logic [6:0]       far_fault_signalling_tx_cnt;
  logic [10:0]      lfsr_tx;
  logic [10:0]      lfsr_rx;
  logic             nrzi_tx;
  logic             rx_prev100;
  logic [6:0]       run_cnt;
  logic [1:0]       pat_cnt;
  logic             jabbing;
  logic [25:0]      jab_cnt;
  logic             aui_active;
  // Link-domain state
  logic [1:0]       lrst_pipe;
  logic [4:0]       sync_l1;
  logic [4:0]       sync_l2;
  logic [4:0]       acc;
  logic             half_tick;
  logic             cur_bit;
  logic             enc_on;
  logic             enc_tail;
  logic             enc_line;
  logic             enc_drive;
  logic             tx_busy;
  logic             rx_prev10;
  logic [2:0]       quiet;
  logic             crs_r;
  logic [3:0]       rx_tail;

  // Management-side synchronised pins
  wire logic mdc_q, mdio_q, strap_q, link_q, sd_q, fib_rx_q, cu_rx_q, tx_act_q, crs_q;
  assign {mdc_q, mdio_q, strap_q, link_q, sd_q, fib_rx_q, cu_rx_q, tx_act_q, crs_q} = sync_m2;
  wire logic mdc_rise = mdc_q & ~mdc_s3;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync_m1 <= 9'h000;
      sync_m2 <= 9'h000;
      mdc_s3  <= 1'b0;
    end else begin
      sync_m1 <= {mdc, mdio_in, fiber_strap_n, link_pulse_ok, fiber_signal_detect,
                  fiber_rx_pair, copper_rx_pair, tx_busy, crs_r};
      sync_m2 <= sync_m1;
      mdc_s3  <= mdc_q;
    end
  end

  // Management frame decode
  wire pmfa_mgmt_hdr_t next_hdr = pmfa_mgmt_hdr_t'({hdr[11:0], mdio_q});
  wire logic pre_done = ones_cnt >= PREAMBLE_ONES;
  wire logic is_read  = hdr.op == OP_READ;
  wire logic is_write = hdr.op == OP_WRITE;
  wire logic hdr_ok   = next_hdr.st1 && (next_hdr.phy == PHY_ADDR)
                        && (next_hdr.op == OP_READ || next_hdr.op == OP_WRITE);
  wire logic hit_bmcr = hdr.regad == REG_BASIC_MODE_CONTROL;
  wire logic hit_basic_mode_status = hdr.regad == REG_BASIC_MODE_STATUS;
  wire logic hit_psts = hdr.regad == REG_PHY_SUMMARY_STATUS;
  wire logic hit_pcs  = hdr.regad == REG_CODING_SUBLAYER_CONFIG;
  wire logic hit_lbr  = hdr.regad == REG_LOOPBACK_BYPASS_CONTROL;
  wire logic hit_ten  = hdr.regad == REG_TENMEG_CONTROL_STATUS;
  wire logic hit_xtra = hdr.regad == REG_PHY_CONTROL_EXTRA;
  wire logic [15:0] wr_data = {shreg[14:0], mdio_q};
  wire logic wr_pulse = mdc_rise && mg_state == MG_DATA && bit_cnt == DATA_LAST && is_write;
  wire logic rd_clear = mdc_rise && mg_state == MG_TURN && bit_cnt == 4'h0 && is_read
                        && hit_basic_mode_status;

  // Read-back words
  wire logic [15:0] rd_bmcr = 16'(cfg.an_enable) << BIT_AN_ENABLE;
  wire logic [15:0] rd_basic_mode_status = 16'(rf_latch) << BIT_REMOTE_FAULT;
  wire logic [15:0] rd_psts = 16'(far_fault_det) << BIT_FAR_FAULT_SEEN;
  wire logic [15:0] rd_pcs  = 16'(cfg.far_fault_enable) << BIT_FAR_FAULT_ENABLE;
  wire logic [15:0] rd_lbr  = (16'(cfg.scrambler_bypass) << BIT_SCRAMBLER_BYPASS)
                              | (16'(cfg.lb_mode) << LB_FIELD_LSB);
  wire logic [15:0] rd_ten  = (16'(aui_active) << BIT_ACTIVE_PORT)
                              | (16'(cfg.port_autoswitch_enable) << BIT_AUTOSWITCH)
                              | (16'(cfg.attach_port_select) << BIT_ATTACH_SELECT)
                              | (16'(cfg.thin) << BIT_THIN);
  wire logic [15:0] rd_xtra = 16'(cfg.fiber_select_bit) << BIT_FIBER_SELECT;
  wire logic [15:0] rd_word = hit_bmcr ? rd_bmcr : hit_basic_mode_status ? rd_basic_mode_status : hit_psts ? rd_psts :
                              hit_pcs ? rd_pcs : hit_lbr ? rd_lbr : hit_ten ? rd_ten :
                              hit_xtra ? rd_xtra : 16'h0000;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mg_state <= MG_IDLE;
      ones_cnt <= 6'h00;
      bit_cnt  <= 4'h0;
      hdr      <= '0;
      shreg    <= 16'h0000;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
    end else if (mdc_rise) begin
      unique case (mg_state)
        MG_IDLE: begin
          mdio_oe <= 1'b0;
          if (mdio_q) begin
            ones_cnt <= pre_done ? ones_cnt : ones_cnt + 6'h01;
          end else begin
            ones_cnt <= 6'h00;
            bit_cnt  <= 4'h0;
            if (pre_done) mg_state <= MG_HDR;
          end
        end
        MG_HDR: begin
          hdr     <= next_hdr;
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == HDR_LAST) begin
            bit_cnt  <= 4'h0;
            mg_state <= hdr_ok ? MG_TURN : MG_IDLE;
          end
        end
        MG_TURN: begin
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'h0 && is_read) begin
            mdio_oe  <= 1'b1;
            mdio_out <= 1'b0;
            shreg    <= rd_word;
          end
          if (bit_cnt == 4'h1) begin
            bit_cnt  <= 4'h0;
            mg_state <= MG_DATA;
            if (is_read) begin
              mdio_out <= shreg[15];
              shreg    <= {shreg[14:0], 1'b0};
            end
          end
        end
        MG_DATA: begin
          bit_cnt  <= bit_cnt + 4'h1;
          mdio_out <= is_read ? shreg[15] : 1'b0;
          shreg    <= is_read ? {shreg[14:0], 1'b0} : wr_data;
          if (bit_cnt == DATA_LAST) begin
            mg_state <= MG_IDLE;
            mdio_oe  <= 1'b0;
            bit_cnt  <= 4'h0;
          end
        end
        default: mg_state <= MG_IDLE;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= CFG_RESET;
    end else if (wr_pulse) begin
      if (hit_bmcr) cfg.an_enable <= wr_data[BIT_AN_ENABLE];
      if (hit_pcs) cfg.far_fault_enable <= wr_data[BIT_FAR_FAULT_ENABLE];
      if (hit_lbr) begin
        cfg.scrambler_bypass <= wr_data[BIT_SCRAMBLER_BYPASS];
        cfg.lb_mode          <= wr_data[LB_FIELD_LSB +: 3];
      end
      if (hit_ten) begin
        cfg.port_autoswitch_enable <= wr_data[BIT_AUTOSWITCH];
        cfg.attach_port_select     <= wr_data[BIT_ATTACH_SELECT];
        cfg.thin                   <= wr_data[BIT_THIN];
      end
      if (hit_xtra) cfg.fiber_select_bit <= wr_data[BIT_FIBER_SELECT];
    end
  end

  // Mode derivation
  wire logic fiber_mode  = strap_fiber | cfg.fiber_select_bit;
  wire logic far_fault_signalling_active = ~cfg.an_enable & (cfg.far_fault_enable | fiber_mode);
  wire logic bypass      = cfg.scrambler_bypass | fiber_mode;
  wire logic far_fault_signalling_send   = far_fault_signalling_active & fiber_mode & ~sd_q & tx_code_idle;
  wire logic tx_key      = lfsr_tx[10] ^ lfsr_tx[8];
  wire logic rx_key      = lfsr_rx[10] ^ lfsr_rx[8];
  wire logic tx_src      = far_fault_det ? 1'b1 : tx_code_bit;
  wire logic tx_sym      = far_fault_signalling_send ? (far_fault_signalling_tx_cnt != FAR_FAULT_SIGNALLING_ONES)
                                     : (tx_src ^ (~bypass & tx_key));
  wire logic rx_line100  = fiber_mode ? fib_rx_q : cu_rx_q;
  wire logic rx_dec      = (rx_line100 ^ rx_prev100) ^ (~bypass & rx_key);
  wire logic pat_end     = ~rx_dec && run_cnt >= FAR_FAULT_SIGNALLING_ONES
                           && (pat_cnt == 2'h0 || run_cnt == FAR_FAULT_SIGNALLING_ONES);
  wire logic data_zero   = ~rx_dec && run_cnt < FAR_FAULT_SIGNALLING_ONES;

  // Strap capture after reset release
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cap_cnt     <= 2'h0;
      strap_fiber <= 1'b0;
    end else if (cap_cnt != 2'h3) begin
      cap_cnt <= cap_cnt + 2'h1;
      if (cap_cnt == 2'h2) strap_fiber <= ~strap_q;
    end
  end

  // 100 Mb/s transmit and receive
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      far_fault_signalling_tx_cnt    <= 7'h00;
      lfsr_tx        <= SCR_SEED;
      lfsr_rx        <= SCR_SEED;
      nrzi_tx        <= 1'b0;
      fiber_tx_pair  <= 1'b0;
      copper_tx_pair <= 1'b0;
      rx_prev100     <= 1'b0;
      rx_code_bit    <= 1'b1;
    end else begin
      far_fault_signalling_tx_cnt    <= (far_fault_signalling_send && far_fault_signalling_tx_cnt != FAR_FAULT_SIGNALLING_ONES) ? far_fault_signalling_tx_cnt + 7'h01 : 7'h00;
      lfsr_tx        <= {lfsr_tx[9:0], tx_key};
      lfsr_rx        <= {lfsr_rx[9:0], rx_key};
      nrzi_tx        <= nrzi_tx ^ tx_sym;
      fiber_tx_pair  <= fiber_mode & nrzi_tx;
      copper_tx_pair <= ~fiber_mode & nrzi_tx;
      rx_prev100     <= rx_line100;
      rx_code_bit    <= far_fault_det | rx_dec;
    end
  end

  // Far-end fault detection and status
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      run_cnt              <= 7'h00;
      pat_cnt              <= 2'h0;
      far_fault_det        <= 1'b0;
      rf_latch             <= 1'b0;
      rx_carrier100        <= 1'b0;
      far_fault_signalling <= 1'b0;
    end else begin
      if (rx_dec) run_cnt <= (run_cnt == RUN_MAX) ? run_cnt : run_cnt + 7'h01;
      else run_cnt <= 7'h00;
      if (pat_end) pat_cnt <= (pat_cnt == FAR_FAULT_SIGNALLING_REPEATS) ? pat_cnt : pat_cnt + 2'h1;
      else if (~rx_dec) pat_cnt <= 2'h0;
      far_fault_det        <= far_fault_signalling_active && pat_cnt == FAR_FAULT_SIGNALLING_REPEATS;
      rf_latch             <= far_fault_det | (rf_latch & ~rd_clear);
      rx_carrier100        <= ~far_fault_det
                              & (data_zero | (rx_carrier100 & run_cnt < CARRIER_IDLE_ONES));
      far_fault_signalling <= far_fault_det;
    end
  end

  // Jabber, autoswitch and thin select
  wire logic port_target = (cfg.port_autoswitch_enable & ~fiber_mode) ? ~link_q
                                                                       : cfg.attach_port_select;
  wire logic port_idle   = ~tx_act_q & ~crs_q & ~jabbing;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      jabbing     <= 1'b0;
      jab_cnt     <= 26'h0000000;
      aui_active  <= 1'b0;
      thin_select <= 1'b0;
    end else begin
      if (!jabbing) begin
        jab_cnt <= tx_act_q ? jab_cnt + 26'h0000001 : 26'h0000000;
        if (tx_act_q && jab_cnt == JAB_LAST) begin
          jabbing <= 1'b1;
          jab_cnt <= 26'h0000000;
        end
      end else begin
        jab_cnt <= tx_act_q ? 26'h0000000 : jab_cnt + 26'h0000001;
        if (!tx_act_q && jab_cnt == UNJAB_LAST) jabbing <= 1'b0;
      end
      if (port_idle) aui_active <= port_target;
      thin_select <= cfg.thin;
    end
  end

  // Link-domain reset release
  wire logic lrst_b = lrst_pipe[1];
  always_ff @(posedge lclk or negedge rst_b) begin
    if (!rst_b) lrst_pipe <= 2'h0;
    else lrst_pipe <= {lrst_pipe[0], 1'b1};
  end

  wire logic aui_l, fault_l, jab_l, tp_rx_l, aui_rx_l;
  assign {aui_l, fault_l, jab_l, tp_rx_l, aui_rx_l} = sync_l2;
  wire logic [5:0] acc_sum  = {1'b0, acc} + ACC_STEP;
  wire logic       acc_wrap = acc_sum >= ACC_MOD;
  wire logic       bit_edge = half_tick & ~tx_clk;
  wire logic       mid_edge = half_tick & tx_clk;
  wire logic       take     = bit_edge & tx_en & ~jab_l & ~fault_l;
  wire logic       rx_line  = aui_l ? aui_rx_l : tp_rx_l;
  wire logic       trans    = rx_line ^ rx_prev10;

  // 10 Mb/s timing and encoder
  always_ff @(posedge lclk or negedge lrst_b) begin
    if (!lrst_b) begin
      sync_l1   <= 5'h00;
      sync_l2   <= 5'h00;
      acc       <= 5'h00;
      half_tick <= 1'b0;
      tx_clk    <= 1'b0;
      cur_bit   <= 1'b0;
      enc_on    <= 1'b0;
      enc_tail  <= 1'b0;
      enc_line  <= 1'b0;
      enc_drive <= 1'b0;
      tx_busy   <= 1'b0;
    end else begin
      sync_l1   <= {aui_active, far_fault_det, jabbing, tp10_rx_line, attach_rx_pair};
      tx_busy   <= tx_en | enc_drive;
      sync_l2   <= sync_l1;
      acc       <= acc_wrap ? 5'(acc_sum - ACC_MOD) : acc_sum[4:0];
      half_tick <= acc_wrap;
      if (half_tick) tx_clk <= ~tx_clk;
      if (take) begin
        cur_bit   <= txd;
        enc_line  <= ~txd;
        enc_on    <= 1'b1;
        enc_drive <= 1'b1;
      end else if (bit_edge && enc_on) begin
        enc_on   <= 1'b0;
        enc_line <= 1'b1;
        enc_tail <= 1'b1;
      end else if (bit_edge && enc_tail) begin
        enc_tail  <= 1'b0;
        enc_line  <= 1'b0;
        enc_drive <= 1'b0;
      end else if (mid_edge && enc_on) begin
        enc_line <= cur_bit;
      end
    end
  end

  // 10 Mb/s decoder and MII receive side
  always_ff @(posedge lclk or negedge lrst_b) begin
    if (!lrst_b) begin
      rx_prev10      <= 1'b0;
      quiet          <= 3'h0;
      crs_r          <= 1'b0;
      rx_tail        <= 4'h0;
      rx_clk         <= 1'b0;
      rxd            <= 1'b0;
      crs            <= 1'b0;
      tp10_tx_line   <= 1'b0;
      attach_tx_pair <= 1'b0;
      tx10_drive     <= 1'b0;
    end else begin
      rx_prev10 <= rx_line;
      if (trans) quiet <= 3'h0;
      else if (half_tick && quiet != 3'h7) quiet <= quiet + 3'h1;
      crs_r <= ~fault_l & (trans | (crs_r & quiet < CRS_OFF_HALVES));
      if (crs_r) rx_tail <= RXCLK_TAIL_HALVES;
      else if (half_tick && rx_tail != 4'h0) rx_tail <= rx_tail - 4'h1;
      rx_clk <= (crs_r || rx_tail != 4'h0) ? (rx_clk ^ half_tick) : 1'b0;
      if (fault_l) rxd <= 1'b0;
      else if (trans && quiet != 3'h0) rxd <= rx_line;
      crs            <= crs_r;
      tp10_tx_line   <= ~aui_l & enc_line;
      attach_tx_pair <= aui_l & enc_line;
      tx10_drive     <= enc_drive;
    end
  end

  // Checks on mclk
  far_fault_signalling_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !far_fault_signalling_active |=> far_fault_signalling_tx_cnt == 7'h00) else $error("fault pattern counting while disabled");
  an_forces_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
    cfg.an_enable |-> !far_fault_signalling_send ##1 !far_fault_det) else $error("fault active under AN");
  copper_quiet_a: assert property (@(posedge mclk) disable iff (!rst_b)
    fiber_mode ##1 fiber_mode |-> !copper_tx_pair) else $error("copper driven in fiber mode");
  fault_latch_a: assert property (@(posedge mclk) disable iff (!rst_b)
    far_fault_det |=> rf_latch && far_fault_signalling) else $error("fault status not latched");
  fault_blocks_mii_a: assert property (@(posedge mclk) disable iff (!rst_b)
    far_fault_det |=> !rx_carrier100 && rx_code_bit) else $error("receive not blocked");
  jabber_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    jabbing && tx_act_q |=> jabbing && jab_cnt == 26'h0000000) else $error("jabber released");
  port_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (tx_act_q || crs_q || jabbing) |=> $stable(aui_active)) else $error("port switched busy");
  strap_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(strap_fiber) |-> ##[0:2] fiber_mode && far_fault_signalling_active == !cfg.an_enable)
    else $error("strap did not select fiber");
  // Checks on lclk
  crs_drop_a: assert property (@(posedge lclk) disable iff (!lrst_b)
    crs_r && !trans && quiet == 3'h3 |=> !crs_r) else $error("carrier held too long");
  rxclk_tail_a: assert property (@(posedge lclk) disable iff (!lrst_b)
    $fell(crs_r) |-> rx_tail == 4'hA ##1 rx_tail != 4'h0) else $error("receive clock stopped");
  enc_end_a: assert property (@(posedge lclk) disable iff (!lrst_b)
    bit_edge && enc_on && !take |=> enc_line && enc_tail && enc_drive)
    else $error("frame end not high");
endmodule
`default_nettype wire

// ---- pmfa_pkg.sv ----
// Shared constants and types of the media-path block
`default_nettype none
package pmfa_pkg;
  // Register addresses
  localparam logic [4:0] REG_BASIC_MODE_CONTROL      = 5'h00;
  localparam logic [4:0] REG_BASIC_MODE_STATUS       = 5'h01;
  localparam logic [4:0] REG_PHY_SUMMARY_STATUS      = 5'h10;
  localparam logic [4:0] REG_CODING_SUBLAYER_CONFIG  = 5'h16;
  localparam logic [4:0] REG_LOOPBACK_BYPASS_CONTROL = 5'h17;
  localparam logic [4:0] REG_TENMEG_CONTROL_STATUS   = 5'h18;
  localparam logic [4:0] REG_PHY_CONTROL_EXTRA       = 5'h19;
  // Field positions
  localparam int BIT_AN_ENABLE        = 12;
  localparam int BIT_REMOTE_FAULT     = 4;
  localparam int BIT_FAR_FAULT_SEEN   = 7;
  localparam int BIT_FAR_FAULT_ENABLE = 14;
  localparam int BIT_SCRAMBLER_BYPASS = 11;
  localparam int LB_FIELD_LSB         = 7;
  localparam int BIT_THIN             = 3;
  localparam int BIT_ATTACH_SELECT    = 5;
  localparam int BIT_AUTOSWITCH       = 9;
  localparam int BIT_ACTIVE_PORT      = 12;
  localparam int BIT_FIBER_SELECT     = 5;
  // Management frame
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [3:0] HDR_LAST      = 4'hC;
  localparam logic [3:0] DATA_LAST     = 4'hF;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  // Far-end fault pattern and 100 Mb/s receive
  localparam logic [6:0]  FAR_FAULT_SIGNALLING_ONES          = 7'h54;
  localparam logic [6:0]  RUN_MAX            = 7'h7F;
  localparam logic [1:0]  FAR_FAULT_SIGNALLING_REPEATS       = 2'h3;
  localparam logic [6:0]  CARRIER_IDLE_ONES  = 7'h0A;
  localparam logic [10:0] SCR_SEED           = 11'h7FF;
  // 10 Mb/s timing from the reference clock
  localparam int          REF_MHZ     = 25;
  localparam int          TX_BIT_MHZ  = 10;
  localparam logic [5:0]  ACC_STEP    = 6'(2 * TX_BIT_MHZ);
  localparam logic [5:0]  ACC_MOD     = 6'(REF_MHZ);
  localparam logic [2:0]  CRS_OFF_HALVES    = 3'h3;
  localparam logic [3:0]  RXCLK_TAIL_HALVES = 4'hA;
  // Jabber timing on mclk
  localparam int MCLK_KHZ          = 125000;
  localparam int JABBER_MS         = 20;
  localparam int UNJAB_MS          = 400;
  localparam int JABBER_CYCLES_DEF = JABBER_MS * MCLK_KHZ;
  localparam int UNJAB_CYCLES_DEF  = UNJAB_MS * MCLK_KHZ;

  typedef enum logic [3:0] {
    MG_IDLE = 4'b0001,
    MG_HDR  = 4'b0010,
    MG_TURN = 4'b0100,
    MG_DATA = 4'b1000
  } pmfa_mgmt_state_t;

  typedef struct packed {
    logic       st1;
    logic [1:0] op;
    logic [4:0] phy;
    logic [4:0] regad;
  } pmfa_mgmt_hdr_t;

  typedef struct packed {
    logic       an_enable;
    logic       far_fault_enable;
    logic       scrambler_bypass;
    logic [2:0] lb_mode;
    logic       thin;
    logic       attach_port_select;
    logic       port_autoswitch_enable;
    logic       fiber_select_bit;
  } pmfa_cfg_t;

  localparam pmfa_cfg_t CFG_RESET = '{an_enable: 1'b1, lb_mode: 3'h0, default: 1'b0};
endpackage
`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench of the media path
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pmfa_pkg::*;
  logic        mclk = 1'b0, lclk = 1'b0, rst_b = 1'b0, mdc = 1'b0;
  logic        mdio_h = 1'b1, sd = 1'b0, send = 1'b0, link = 1'b1, strap_n = 1'b1;
  wire         mdio_out, mdio_oe, tx_en, txd, tx_clk, tp10_tx, attach_tx;
  wire         fib_tx, cop_tx, thin_select, tx10_drive, far_fault, carrier100;
  wire         rx_code, rx_clk, rxd, crs;
  wire         mdio_in = mdio_oe ? mdio_out : mdio_h;
  int          errors = 0, check_count = 0, cyc = 0;
  logic [15:0] rd;
  pmfa_media_path #(.JABBER_CYCLES(40), .UNJAB_CYCLES(200)) i_pmfa_media_path (
    .mclk, .rst_b, .lclk, .mdc, .mdio_in, .mdio_out, .mdio_oe,
    .fiber_strap_n(strap_n), .link_pulse_ok(link), .tx_code_bit(1'b1), .tx_code_idle(1'b1),
    .rx_code_bit(rx_code), .rx_carrier100(carrier100), .far_fault_signalling(far_fault),
    .fiber_rx_pair(fib_tx), .copper_rx_pair(cop_tx), .fiber_signal_detect(sd),
    .fiber_tx_pair(fib_tx), .copper_tx_pair(cop_tx), .tx_en, .txd, .tx_clk,
    .rx_clk, .rxd, .crs, .tp10_rx_line(tp10_tx), .attach_rx_pair(attach_tx),
    .tp10_tx_line(tp10_tx), .attach_tx_pair(attach_tx), .tx10_drive, .thin_select);
  pmfa_mac_model i_pmfa_mac_model (.tx_clk, .send, .tx_en, .txd);
  always #4 mclk = ~mclk;
  always #15 lclk = ~lclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      final_report();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask
  // One management frame; read data is taken while each bit stands
  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] w);
    logic [63:0] v;
    v = {32'hFFFFFFFF, 2'b01, op, 5'h01, ra, 2'b10, w};
    for (int i = 63; i >= 0; i--) begin
      if (i < 16) rd[i] = mdio_out;
      mdio_h = v[i];
      tick(10);
      mdc = 1'b1;
      tick(10);
      mdc = 1'b0;
    end
  endtask
  task automatic rdchk(input logic [4:0] ra, input logic [15:0] exp);
    frame(OP_READ, ra, 16'hFFFF);
    chk("register", exp, rd);
  endtask
  task automatic final_report();
    if (errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    // Reset spans three link clock periods
    tick(12);
    rst_b = 1'b1;
    tick(4);
    rdchk(REG_BASIC_MODE_CONTROL, 16'h1000);
    rdchk(5'h05, 16'h0000);
    frame(OP_WRITE, REG_TENMEG_CONTROL_STATUS, 16'h0028);
    chk("thin_select", 16'h0001, {15'h0, thin_select});
    rdchk(REG_TENMEG_CONTROL_STATUS, 16'h1028);
    frame(OP_WRITE, REG_LOOPBACK_BYPASS_CONTROL, 16'h0980);
    rdchk(REG_LOOPBACK_BYPASS_CONTROL, 16'h0980);
    chk("far_fault", 16'h0000, {15'h0, far_fault});
    frame(OP_WRITE, REG_TENMEG_CONTROL_STATUS, 16'h0000);
    send = 1'b1;
    tick(26);
    chk("tx10_drive", 16'h0001, {15'h0, tx10_drive});
    tick(24);
    chk("crs", 16'h0001, {15'h0, crs});
    tick(376);
    chk("tx10_drive", 16'h0000, {15'h0, tx10_drive});
    send = 1'b0;
    tick(20);
    chk("tp10_tx", 16'h0000, {15'h0, tp10_tx});
    chk("crs", 16'h0000, {15'h0, crs});
    chk("rx_clk", 16'h0000, {15'h0, rx_clk});
    frame(OP_WRITE, REG_TENMEG_CONTROL_STATUS, 16'h0200);
    rdchk(REG_TENMEG_CONTROL_STATUS, 16'h0200);
    link = 1'b0;
    tick(10);
    rdchk(REG_TENMEG_CONTROL_STATUS, 16'h1200);
    link = 1'b1;
    frame(OP_WRITE, REG_BASIC_MODE_CONTROL, 16'h0000);
    frame(OP_WRITE, REG_PHY_CONTROL_EXTRA, 16'h0020);
    tick(500);
    chk("far_fault", 16'h0001, {15'h0, far_fault});
    chk("carrier100", 16'h0000, {15'h0, carrier100});
    chk("copper_tx", 16'h0000, {15'h0, cop_tx});
    chk("rx_code", 16'h0001, {15'h0, rx_code});
    chk("rxd", 16'h0000, {15'h0, rxd});
    rdchk(REG_PHY_SUMMARY_STATUS, 16'h0080);
    rdchk(REG_BASIC_MODE_STATUS, 16'h0010);
    send = 1'b1;
    tick(30);
    chk("tx10_drive", 16'h0000, {15'h0, tx10_drive});
    send = 1'b0;
    tick(20);
    // Second reset with the strap low selects fiber
    strap_n = 1'b0;
    rst_b = 1'b0;
    tick(12);
    rst_b = 1'b1;
    tick(6);
    chk("copper_tx", 16'h0000, {15'h0, cop_tx});
    rd[0] = fib_tx;
    tick(1);
    chk("fiber_tx", {15'h0, ~rd[0]}, {15'h0, fib_tx});
    final_report();
  end
endmodule
`default_nettype wire
